// ==== hdl/fsps_device.sv ====
// How it works
// R1: Erase clears exactly one 32-word row
// R2: Panel is 128 rows, own write latches
// R3: Program writes all 32 latches at once
// R4: Software loads latches in order, aligned group
// R5: Low table ops reach bits 15..0
// R6: High table ops reach bits 23..16
// R7: Address is page byte joined with EA
// R8: Table write takes 2 cycles, latches only
// R9: Low address register captures EA 15..0
// R10: High address register captures EA 23..16
// R11: Software may write both address registers
// R12: Key 0x55 then 0xAA unlocks, write-only
// R13: Control holds erase, program and start
// R14: Start bit self-clears on completion
// R15: Operation lasts 2 ms, core stalls
// R16: Erase sequence: control, address, keys, start
// R17: Program sequence: latches, control, keys, start
// R18: Partial update copies, erases, reprograms row
// R19: Two idle slots follow the start write
// R20: Start needs permit bit and fresh unlock
// R21: Completion raises a visible done event
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "fsps_consts.svh"
module fsps_device import fsps_pkg::*; #(
    parameter int unsigned OP_CYCLES = `FSPS_OP_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    // Core link
    fsps_if.dev link,
    // Status
    output logic busy
);
    logic [23:0] flash_mem [0:`FSPS_PANEL_WORDS-1];
    logic [23:0] write_latch [0:`FSPS_ROW_WORDS-1];
    logic [15:0] flash_control_reg;
    logic [15:0] row_address_low_reg;
    logic [7:0] row_address_high_reg;
    logic [7:0] table_page_reg;
    fsps_key_e key_state;
    fsps_dev_state_e state;
    logic ack_q;
    logic stall_q;
    logic done_q;
    logic [15:0] rdata_q;
    logic [15:0] next_rdata;
    logic take;
    logic is_table;
    logic is_write;
    logic start_req;
    logic op_valid;
    logic launch;
    logic timer_expired;
    logic [23:0] prog_addr;
    logic [23:0] read_word;
    logic [4:0] latch_idx;
    logic [6:0] row_sel;

    assign link.ack = ack_q;
    assign link.rdata = rdata_q;
    assign link.stall = stall_q;
    assign link.done = done_q;
    assign busy = stall_q;

    // Requests are taken only while idle; the held request of an answered cycle is skipped
    assign take = link.req && !ack_q && (state == dev_idle); // R15
    assign is_table = (link.op == op_read_low) || (link.op == op_read_high) ||
                      (link.op == op_write_low) || (link.op == op_write_high);
    assign is_write = (link.op == op_write_low) || (link.op == op_write_high) || (link.op == op_reg_write);
    assign prog_addr = {table_page_reg, link.ea}; // R7
    assign read_word = flash_mem[prog_addr[12:1]]; // R2
    assign latch_idx = link.ea[5:1]; // R4
    assign row_sel = row_address_low_reg[12:6]; // R9

    assign start_req = take && (link.op == op_reg_write) && (link.sel == reg_control) &&
                       link.wdata[`FSPS_CTL_START_BIT] && link.wdata[`FSPS_CTL_PERMIT_BIT] &&
                       (key_state == key_armed); // R20
    assign op_valid = (link.wdata[`FSPS_CTL_OP_MSB:0] == `FSPS_OP_ERASE_ROW) ||
                      (link.wdata[`FSPS_CTL_OP_MSB:0] == `FSPS_OP_PROG_ROW);
    assign launch = start_req && op_valid;

    fsps_timer #(
        .CYCLES(OP_CYCLES)
    ) u_timer (
        .clock(clock),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .start(launch),
        .expired(timer_expired)
    );

    // Read answer for table reads and register reads
    always_comb begin
        next_rdata = 16'h0000;
        case (link.op)
            op_read_low: begin // R5
                if (!link.byte_mode) begin
                    next_rdata = read_word[15:0];
                end else if (link.ea[0]) begin
                    next_rdata = {8'h00, read_word[15:8]};
                end else begin
                    next_rdata = {8'h00, read_word[7:0]};
                end
            end
            op_read_high: begin // R6
                if (!(link.byte_mode && link.ea[0])) begin
                    next_rdata = {8'h00, read_word[23:16]};
                end
            end
            op_reg_read: begin
                case (link.sel)
                    reg_control: next_rdata = flash_control_reg;
                    reg_addr_low: next_rdata = row_address_low_reg;
                    reg_addr_high: next_rdata = {8'h00, row_address_high_reg};
                    reg_page: next_rdata = {8'h00, table_page_reg};
                    default: next_rdata = 16'h0000; // R12
                endcase
            end
            default: next_rdata = 16'h0000;
        endcase
    end

    // Sequencer
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= dev_idle;
            ack_q <= 1'b0;
            stall_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else if (clk_en) begin
            ack_q <= 1'b0;
            done_q <= 1'b0;
            case (state)
                dev_idle: begin
                    if (take) begin
                        // Table writes leave the last answer standing on rdata
                        if ((link.op == op_write_low) || (link.op == op_write_high)) begin
                            state <= dev_twait; // R8
                        end else begin
                            rdata_q <= next_rdata;
                            ack_q <= 1'b1;
                            if (launch) begin
                                state <= dev_busy; // R15
                                stall_q <= 1'b1;
                            end
                        end
                    end
                end
                dev_twait: begin
                    ack_q <= 1'b1; // R8
                    state <= dev_idle;
                end
                dev_busy: begin
                    if (timer_expired) begin
                        state <= dev_idle;
                        stall_q <= 1'b0;
                        done_q <= 1'b1; // R21
                    end
                end
                default: begin
                    state <= dev_idle;
                    stall_q <= 1'b0;
                end
            endcase
        end
    end

    // Unlock key tracking; any other write discards a partial unlock
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            key_state <= key_none;
        end else if (clk_en) begin
            if (take && is_write) begin
                if ((link.op == op_reg_write) && (link.sel == reg_key)) begin
                    if (link.wdata[7:0] == `FSPS_KEY_FIRST) begin
                        key_state <= key_first; // R12
                    end else if ((link.wdata[7:0] == `FSPS_KEY_SECOND) && (key_state == key_first)) begin
                        key_state <= key_armed; // R12
                    end else begin
                        key_state <= key_none; // R20
                    end
                end else begin
                    key_state <= key_none; // R20
                end
            end
        end
    end

    // Flash control register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flash_control_reg <= `FSPS_CTL_RESET;
        end else if (clk_en) begin
            if (timer_expired) begin
                flash_control_reg[`FSPS_CTL_START_BIT] <= 1'b0; // R14
            end else if (take && (link.op == op_reg_write) && (link.sel == reg_control)) begin
                flash_control_reg <= link.wdata & `FSPS_CTL_WRITABLE; // R13
                if (launch) begin
                    flash_control_reg[`FSPS_CTL_START_BIT] <= 1'b1; // R14
                end
                if (start_req && !op_valid) begin
                    flash_control_reg[`FSPS_CTL_ERROR_BIT] <= 1'b1;
                end
            end
        end
    end

    // Address and page registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            row_address_low_reg <= 16'h0000;
            row_address_high_reg <= 8'h00;
            table_page_reg <= 8'h00;
        end else if (clk_en) begin
            if (take && is_table) begin
                row_address_low_reg <= prog_addr[15:0]; // R9
                row_address_high_reg <= prog_addr[23:16]; // R10
            end else if (take && (link.op == op_reg_write)) begin
                case (link.sel)
                    reg_addr_low: row_address_low_reg <= link.wdata; // R11
                    reg_addr_high: row_address_high_reg <= link.wdata[7:0]; // R11
                    reg_page: table_page_reg <= link.wdata[7:0];
                    default: table_page_reg <= table_page_reg;
                endcase
            end
        end
    end

    // Write latches: filled by table writes only, never the array
    always_ff @(posedge clock) begin
        if (clk_en && (state == dev_twait)) begin
            if (link.op == op_write_low) begin // R5
                if (!link.byte_mode) begin
                    write_latch[latch_idx][15:0] <= link.wdata;
                end else if (link.ea[0]) begin
                    write_latch[latch_idx][15:8] <= link.wdata[7:0];
                end else begin
                    write_latch[latch_idx][7:0] <= link.wdata[7:0];
                end
            end else if (!(link.byte_mode && link.ea[0])) begin
                write_latch[latch_idx][23:16] <= link.wdata[7:0]; // R6
            end
        end
    end

    // Array update at the end of an operation
    always_ff @(posedge clock) begin
        if (clk_en && timer_expired) begin
            for (int i = 0; i < `FSPS_ROW_WORDS; i++) begin
                if (flash_control_reg[`FSPS_CTL_OP_MSB:0] == `FSPS_OP_ERASE_ROW) begin
                    flash_mem[{row_sel, 5'(i)}] <= `FSPS_ERASED_WORD; // R1
                end else begin
                    flash_mem[{row_sel, 5'(i)}] <= write_latch[i]; // R3
                end
            end
        end
    end
endmodule : fsps_device

// ==== hdl/fsps_consts.svh ====
`ifndef FSPS_CONSTS_SVH
`define FSPS_CONSTS_SVH

// Timing
`define FSPS_CLK_MHZ 50
`define FSPS_OP_TIME_US 2000
`define FSPS_OP_CYCLES (`FSPS_OP_TIME_US * `FSPS_CLK_MHZ)
`define FSPS_TBLWT_CYCLES 2
`define FSPS_NOP_SLOTS 2

// Array geometry
`define FSPS_ROW_WORDS 32
`define FSPS_PANEL_ROWS 128
`define FSPS_PANEL_WORDS (`FSPS_ROW_WORDS * `FSPS_PANEL_ROWS)
`define FSPS_ERASED_WORD 24'hFFFFFF

// Unlock keys
`define FSPS_KEY_FIRST 8'h55
`define FSPS_KEY_SECOND 8'hAA

// Flash control register fields
`define FSPS_CTL_START_BIT 15
`define FSPS_CTL_PERMIT_BIT 14
`define FSPS_CTL_ERROR_BIT 13
`define FSPS_CTL_OP_MSB 6
`define FSPS_CTL_WRITABLE 16'h607F
`define FSPS_CTL_RESET 16'h0000
`define FSPS_OP_ERASE_ROW 7'h41
`define FSPS_OP_PROG_ROW 7'h01

// Controller registers on the Avalon side (byte addresses)
`define FSPS_AV_CMD 5'h00
`define FSPS_AV_EA 5'h04
`define FSPS_AV_WDATA 5'h08
`define FSPS_AV_RDATA 5'h0C
`define FSPS_AV_STATUS 5'h10
`define FSPS_CMD_OP_MSB 2
`define FSPS_CMD_BYTE_BIT 3
`define FSPS_CMD_SEL_LSB 4
`define FSPS_CMD_SEL_MSB 6
`define FSPS_ST_BUSY_BIT 0
`define FSPS_ST_DONE_BIT 1

`endif

// ==== hdl/fsps_pkg.sv ====
package fsps_pkg;

    typedef enum logic [2:0] {
        op_read_low = 3'h0,
        op_read_high = 3'h1,
        op_write_low = 3'h2,
        op_write_high = 3'h3,
        op_reg_write = 3'h4,
        op_reg_read = 3'h5
    } fsps_op_e;

    typedef enum logic [2:0] {
        reg_control = 3'h0,
        reg_addr_low = 3'h1,
        reg_addr_high = 3'h2,
        reg_key = 3'h3,
        reg_page = 3'h4
    } fsps_reg_e;

    typedef enum logic [2:0] {
        key_none = 3'b001,
        key_first = 3'b010,
        key_armed = 3'b100
    } fsps_key_e;

    typedef enum logic [2:0] {
        dev_idle = 3'b001,
        dev_twait = 3'b010,
        dev_busy = 3'b100
    } fsps_dev_state_e;

    typedef enum logic [3:0] {
        cpu_idle = 4'b0001,
        cpu_link = 4'b0010,
        cpu_answer = 4'b0100,
        cpu_gap = 4'b1000
    } fsps_cpu_state_e;

endpackage : fsps_pkg

// ==== hdl/fsps_if.sv ====
`timescale 1ns/1ps
interface fsps_if;
    import fsps_pkg::*;

    logic req;
    fsps_op_e op;
    fsps_reg_e sel;
    logic byte_mode;
    logic [15:0] ea;
    logic [15:0] wdata;
    logic ack;
    logic [15:0] rdata;
    logic stall;
    logic done;

    modport dev (input req, op, sel, byte_mode, ea, wdata, output ack, rdata, stall, done);
    modport cpu (output req, op, sel, byte_mode, ea, wdata, input ack, rdata, stall, done);
endinterface : fsps_if

// ==== hdl/fsps_timer.sv ====
`timescale 1ns/1ps
module fsps_timer #(
    parameter int unsigned CYCLES = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    // Control
    input wire logic start,
    output logic expired
);
    logic [31:0] count;
    logic running;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count <= 32'h0;
            running <= 1'b0;
            expired <= 1'b0;
        end else if (clk_en) begin
            expired <= 1'b0;
            if (start) begin
                running <= 1'b1;
                count <= 32'h0;
            end else if (running) begin
                if (count == 32'(CYCLES - 1)) begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end else begin
                    count <= count + 32'h1;
                end
            end
        end
    end
endmodule : fsps_timer

// ==== hdl/fsps_cpu_end.sv ====
`timescale 1ns/1ps
`include "fsps_consts.svh"
module fsps_cpu_end import fsps_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Core link
    fsps_if.cpu link
);
    fsps_cpu_state_e state;
    logic req_q;
    fsps_op_e op_q;
    fsps_reg_e sel_q;
    logic byte_q;
    logic [15:0] ea_q;
    logic [15:0] wdata_q;
    logic [15:0] rdata_q;
    logic done_flag;
    logic [1:0] gap_count;
    logic ctl_write;

    assign link.req = req_q;
    assign link.op = op_q;
    assign link.sel = sel_q;
    assign link.byte_mode = byte_q;
    assign link.ea = ea_q;
    assign link.wdata = wdata_q;
    assign ctl_write = (op_q == op_reg_write) && (sel_q == reg_control);

    // One core request at a time, held until answered
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= cpu_idle;
            req_q <= 1'b0;
            op_q <= op_reg_read;
            sel_q <= reg_control;
            byte_q <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
            rdata_q <= 16'h0000;
            gap_count <= 2'h0;
        end else if (clk_en) begin
            case (state)
                cpu_idle: begin
                    if (avs_write && (avs_address == `FSPS_AV_CMD)) begin
                        op_q <= fsps_op_e'(avs_writedata[`FSPS_CMD_OP_MSB:0]); // R16 R17 R18
                        byte_q <= avs_writedata[`FSPS_CMD_BYTE_BIT];
                        sel_q <= fsps_reg_e'(avs_writedata[`FSPS_CMD_SEL_MSB:`FSPS_CMD_SEL_LSB]);
                        req_q <= 1'b1;
                        state <= cpu_link;
                    end else if (avs_read || avs_write) begin
                        case (avs_address)
                            `FSPS_AV_EA: avs_readdata <= {16'h0000, ea_q};
                            `FSPS_AV_WDATA: avs_readdata <= {16'h0000, wdata_q};
                            `FSPS_AV_RDATA: avs_readdata <= {16'h0000, rdata_q};
                            `FSPS_AV_STATUS: avs_readdata <= {30'h0, done_flag, link.stall};
                            default: avs_readdata <= 32'h0;
                        endcase
                        avs_waitrequest <= 1'b0;
                        state <= cpu_answer;
                    end
                end
                cpu_link: begin
                    if (link.ack) begin
                        req_q <= 1'b0;
                        rdata_q <= link.rdata;
                        avs_readdata <= 32'h0;
                        avs_waitrequest <= 1'b0;
                        state <= cpu_answer;
                    end
                end
                cpu_answer: begin
                    avs_waitrequest <= 1'b1;
                    gap_count <= 2'(`FSPS_NOP_SLOTS);
                    // Only the command that wrote the control register earns the idle slots
                    state <= (avs_write && (avs_address == `FSPS_AV_CMD) && ctl_write) ? cpu_gap : cpu_idle; // R19
                end
                cpu_gap: begin
                    gap_count <= gap_count - 2'h1;
                    if (gap_count == 2'h1) begin
                        state <= cpu_idle;
                    end
                end
                default: begin
                    state <= cpu_idle;
                    req_q <= 1'b0;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // Operand registers, written at the answering edge
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ea_q <= 16'h0000;
            wdata_q <= 16'h0000;
        end else if (clk_en && (state == cpu_answer) && avs_write) begin
            if (avs_address == `FSPS_AV_EA) begin
                ea_q <= avs_writedata[15:0]; // R4
            end else if (avs_address == `FSPS_AV_WDATA) begin
                wdata_q <= avs_writedata[15:0];
            end
        end
    end

    // Sticky completion flag, write one to clear, a new event wins
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            done_flag <= 1'b0;
        end else if (clk_en) begin
            if (link.done) begin
                done_flag <= 1'b1; // R21
            end else if ((state == cpu_answer) && avs_write && (avs_address == `FSPS_AV_STATUS) &&
                         avs_writedata[`FSPS_ST_DONE_BIT]) begin
                done_flag <= 1'b0;
            end
        end
    end
endmodule : fsps_cpu_end

// ==== tb/fsps_monitor.sv ====
`timescale 1ns/1ps
module fsps_monitor import fsps_pkg::*; #(
    parameter int unsigned OP_CYCLES = 20
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Link
    input wire logic req,
    input fsps_op_e op,
    input wire logic [15:0] ea,
    input wire logic [15:0] wdata,
    input wire logic ack,
    input wire logic [15:0] rdata,
    input wire logic stall,
    input wire logic done
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    int unsigned stall_len;

    // Cycles the current operation has held the core
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stall_len <= 0;
        end else if (stall) begin
            stall_len <= stall_len + 1;
        end else begin
            stall_len <= 0;
        end
    end

    sequence s_tw_req;
        $rose(req) && !stall && (op == op_write_low || op == op_write_high);
    endsequence
    sequence s_other_req;
        $rose(req) && !stall && op != op_write_low && op != op_write_high;
    endsequence
    sequence s_op_end;
        $fell(stall) ##1 !done;
    endsequence

    AST_TBLWT_TWO: assert property (s_tw_req |=> !ack ##1 ack) else $error("table write answer timing");
    AST_ANSWER_ONE: assert property (s_other_req |=> ack) else $error("read or register answer timing");
    AST_ACK_PULSE: assert property (ack |=> !ack) else $error("ack longer than one cycle");
    AST_REQ_HOLD: assert property (req && !ack |=> req && $stable(op) && $stable(ea) && $stable(wdata))
        else $error("request changed before answer");
    AST_STALL_ACK: assert property ($rose(stall) |-> ack) else $error("stall without start answer");
    // Stall covers the timer count plus the edge that closes the operation
    AST_STALL_LEN: assert property ($fell(stall) |-> stall_len == OP_CYCLES + 1) else $error("operation length");
    AST_END_DONE: assert property ($fell(stall) |-> done) else $error("no done at end");
    AST_DONE_CAUSE: assert property (done |-> s_op_end) else $error("done without end");
    AST_QUIET_STALL: assert property (stall && $past(stall) |-> !ack) else $error("answer during stall");
    AST_RDATA_STANDS: assert property (!ack |-> $stable(rdata)) else $error("rdata moved");
endmodule : fsps_monitor

// ==== tb/fsps_tb.sv ====
`timescale 1ns/1ps
`include "fsps_consts.svh"
module fsps_tb import fsps_pkg::*;;
    localparam int unsigned OP_CYC = 20;
    localparam logic [15:0] ROW = 16'h0080;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic busy;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;

    fsps_if link_if ();
    fsps_device #(.OP_CYCLES(OP_CYC)) fsps_device_i (.clock(clock), .reset_n(reset_n), .clk_en(1'b1),
        .link(link_if.dev), .busy(busy));
    fsps_cpu_end fsps_cpu_end_i (.clock(clock), .reset_n(reset_n), .clk_en(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link_if.cpu));
    fsps_monitor #(.OP_CYCLES(OP_CYC)) fsps_monitor_i (.clock(clock), .reset_n(reset_n), .req(link_if.req),
        .op(link_if.op), .ea(link_if.ea), .wdata(link_if.wdata), .ack(link_if.ack), .rdata(link_if.rdata),
        .stall(link_if.stall), .done(link_if.done));

    always #10 clock = ~clock;

    task automatic end_of_test();
        if (fails == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fails = fails + 1;
            end_of_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clock);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : av

    task automatic lk(input fsps_op_e op, input fsps_reg_e sel, input logic bm, input logic [15:0] ea,
        input logic [15:0] wd, output logic [15:0] rd);
        logic [31:0] q;
        av(1'b1, `FSPS_AV_EA, {16'h0000, ea}, q);
        av(1'b1, `FSPS_AV_WDATA, {16'h0000, wd}, q);
        av(1'b1, `FSPS_AV_CMD, {25'h0000000, sel, bm, op}, q);
        av(1'b0, `FSPS_AV_RDATA, 32'h00000000, q);
        rd = q[15:0];
    endtask : lk

    task automatic reg_wr(input fsps_reg_e sel, input logic [15:0] v);
        logic [15:0] rd;
        lk(op_reg_write, sel, 1'b0, 16'h0000, v, rd);
    endtask : reg_wr

    task automatic reg_chk(input fsps_reg_e sel, input logic [15:0] exp);
        logic [15:0] rd;
        lk(op_reg_read, sel, 1'b0, 16'h0000, 16'h0000, rd);
        chk(rd, exp);
    endtask : reg_chk

    // Start with keys k1,k2; a locked start must leave the core free
    task automatic start_op(input logic [15:0] k1, input logic [15:0] k2, input logic [15:0] ctl, input logic runs);
        logic [31:0] q;
        reg_wr(reg_key, k1);
        reg_wr(reg_key, k2);
        reg_wr(reg_control, ctl);
        av(1'b0, `FSPS_AV_STATUS, 32'h00000000, q);
        chk(q[15:0], {15'h0000, runs});
        if (runs) begin
            do av(1'b0, `FSPS_AV_STATUS, 32'h00000000, q); while (q[1] !== 1'b1);
            chk(q[15:0], 16'h0002);
            av(1'b1, `FSPS_AV_STATUS, 32'h00000002, q);
        end
        reg_chk(reg_control, ctl & 16'h7FFF);
    endtask : start_op

    task automatic rd_row(input logic erased);
        logic [15:0] rd;
        for (int i = 0; i < 32; i++) begin
            lk(op_read_low, reg_control, 1'b0, ROW + 16'(2 * i), 16'h0000, rd);
            chk(rd, erased ? 16'hFFFF : 16'hA000 + 16'(i));
            lk(op_read_high, reg_control, 1'b0, ROW + 16'(2 * i), 16'h0000, rd);
            chk({8'h00, rd[7:0]}, erased ? 16'h00FF : 16'h0030 + 16'(i));
        end
    endtask : rd_row

    task automatic t_reset();
        reg_chk(reg_control, 16'h0000);
        reg_chk(reg_addr_low, 16'h0000);
    endtask : t_reset

    task automatic t_locked();
        start_op(16'h0000, 16'h0000, 16'hC041, 1'b0);
        start_op(16'h00AA, 16'h0055, 16'hC041, 1'b0);
        start_op(16'h0055, 16'h00AA, 16'h8041, 1'b0);
        // Unlocked start with an unknown operation code flags an error and stays idle
        reg_wr(reg_key, 16'h0055);
        reg_wr(reg_key, 16'h00AA);
        reg_wr(reg_control, 16'hC042);
        reg_chk(reg_control, 16'h6042);
        reg_chk(reg_key, 16'h0000);
    endtask : t_locked

    task automatic t_erase();
        reg_wr(reg_addr_low, ROW);
        reg_chk(reg_addr_low, ROW);
        start_op(16'h0055, 16'h00AA, 16'hC041, 1'b1);
        rd_row(1'b1);
    endtask : t_erase

    task automatic t_program();
        logic [15:0] rd;
        reg_wr(reg_page, 16'h0012);
        for (int i = 0; i < 32; i++) begin
            lk(op_write_low, reg_control, 1'b0, ROW + 16'(2 * i), 16'hA000 + 16'(i), rd);
            lk(op_write_high, reg_control, 1'b0, ROW + 16'(2 * i), 16'hC330 + 16'(i), rd);
        end
        reg_chk(reg_addr_low, ROW + 16'h003E);
        reg_chk(reg_addr_high, 16'h0012);
        lk(op_read_low, reg_control, 1'b0, ROW, 16'h0000, rd);
        chk(rd, 16'hFFFF);
        start_op(16'h0055, 16'h00AA, 16'hC001, 1'b1);
        rd_row(1'b0);
        lk(op_read_low, reg_control, 1'b1, ROW + 16'h000A, 16'h0000, rd);
        chk({8'h00, rd[7:0]}, 16'h0005);
        lk(op_read_low, reg_control, 1'b1, ROW + 16'h000B, 16'h0000, rd);
        chk({8'h00, rd[7:0]}, 16'h00A0);
    endtask : t_program

    initial begin
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        t_reset();
        t_locked();
        t_erase();
        t_program();
        end_of_test();
    end
endmodule : fsps_tb
